/* File: rtl/eis_map.vh */
// Register offsets, field positions, reset values and timing counts of the interrupt front end
`ifndef EIS_MAP_VH
`define EIS_MAP_VH
`define EIS_ADDR_MCU_CONTROL     8'h55
`define EIS_ADDR_SENSE_LOW       8'h69
`define EIS_ADDR_SENSE_HIGH      8'h6A
`define EIS_ADDR_IRQ_MASK        8'h3D
`define EIS_ADDR_IRQ_FLAGS       8'h3C
`define EIS_ADDR_PC_CONTROL      8'h68
`define EIS_ADDR_PC_FLAGS        8'h3B
`define EIS_ADDR_PC_MASK_ZERO    8'h6B
`define EIS_ADDR_PC_MASK_ONE     8'h6C
`define EIS_ADDR_PC_MASK_TWO     8'h6D
`define EIS_ADDR_SYS_CONTROL     8'h70
`define EIS_BIT_UNLOCK           0
`define EIS_BIT_VSEL             1
`define EIS_BIT_PUD              4
`define EIS_BIT_JTD              7
`define EIS_BIT_GIE              0
`define EIS_BIT_APP_LOCK         1
`define EIS_BIT_BOOT_LOCK        2
`define EIS_BIT_IN_BOOT          3
`define EIS_BIT_HANDLER_ACK      4
`define EIS_RST_BYTE             8'h00
`define EIS_SENSE_LEVEL          2'b00
`define EIS_SENSE_ANY            2'b01
`define EIS_SENSE_FALL           2'b10
`define EIS_SENSE_RISE           2'b11
`define EIS_UNLOCK_WIN_CYC       3'd4
`endif

/* File: rtl/eis_top.v */
// External interrupt sense, pin-change groups and vector table relocation guard
//
// Notes on behaviour
// - Vector base is zero with select clear, else the boot section start from fuses.
// - Unlock clears itself four cycles after set, or at once on select write.
// - Interrupts blocked from unlock until after next instruction, or four cycles.
// - The automatic blocking leaves the global enable flag untouched.
// - Boot lock bits suppress interrupts in the section away from the vectors.
// - Pin activity triggers interrupts even when pins drive as outputs.
// - Group two covers inputs 23:16, one 15:8, zero 7:0, each masked per pin.
// - Pin-change detection on all inputs runs on samples taken on the clock.
// - Low level and edges on dedicated pins 3:0 are detected on clocked samples, as on pins 7:4.
// - Enabled level-sensed pin requests continuously while held low.
// - A low level gone before start-up ends raises no interrupt.
// - A dedicated pin interrupts only with global enable and its mask set.
// - Pins 3:0 sense: 00 low, 01 any edge, 10 falling, 11 rising.
// - Pins 7:4 are sampled on the clock; pulses over two periods are caught.
// - Pins 7:4 sense: 00 low, 01 change, 10 falling, 11 rising between samples.
// - Changing sense bits may raise a spurious request.
// - Edge sets pin flag; cleared by handler entry or writing one; clear in level mode.
// - A pin-change input counts only with its mask bit and group enable set.
// - Group flag sets on any masked change in an enabled group; clears on handler entry or writing one.
//
// Added by the designer: strobed register access.
`include "eis_map.vh"
`default_nettype none

module eis_top (
    // Clock and reset
    input  wire        ref_clk,
    input  wire        sys_rst,
    // Register port
    input  wire [7:0]  reg_addr,
    input  wire [7:0]  reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [7:0]  reg_rdata,
    // Pins
    input  wire [7:0]  dedicated_irq_pins,
    input  wire [23:0] pin_change_inputs,
    // Fuses and core state
    input  wire [1:0]  boot_size_fuses,
    input  wire [7:0]  handler_ack,
    input  wire [2:0]  group_ack,
    input  wire        instr_done,
    input  wire        startup_done,
    // Requests and vector control
    output reg  [7:0]  ext_irq_req,
    output reg  [2:0]  group_irq_req,
    output reg         irq_block,
    output reg  [17:0] vector_base
);

    reg  [7:0]  mcu_control;
    reg  [7:0]  ext_sense_control_low;
    reg  [7:0]  ext_sense_control_high;
    reg  [7:0]  ext_irq_mask;
    reg  [7:0]  ext_irq_flags;
    reg  [2:0]  pc_enable;
    reg  [2:0]  pc_flags;
    reg  [7:0]  pin_change_mask_zero;
    reg  [7:0]  pin_change_mask_one;
    reg  [7:0]  pin_change_mask_two;
    reg  [7:0]  sys_control;
    reg  [2:0]  unlock_cnt;
    reg         block_tail;
    reg  [2:0]  lvl_s1;
    reg  [2:0]  lvl_s2;
    reg  [2:0]  lvl_s3;
    reg  [7:0]  smp_q0;
    reg  [7:0]  smp_q1;
    reg  [7:0]  smp_q2;
    reg  [7:0]  smp_prev;
    reg  [23:0] pc_q0;
    reg  [23:0] pc_q1;
    reg  [23:0] pc_q2;
    reg  [23:0] pc_prev;
    reg  [7:0]  next_flags;
    reg  [2:0]  next_pc_flags;
    reg  [7:0]  next_req;
    reg  [7:0]  next_rdata;
    reg  [7:0]  pin_now;
    reg  [23:0] pc_now;
    reg  [23:0] pc_diff;
    reg  [7:0]  hit;
    reg  [15:0] sense_all;
    reg  [2:0]  grp_hit;
    reg  [17:0] boot_start;
    integer     i;
    integer     j;

    wire        gie       = sys_control[`EIS_BIT_GIE];
    wire        in_boot   = sys_control[`EIS_BIT_IN_BOOT];
    wire        wr_mcu    = reg_wr && (reg_addr == `EIS_ADDR_MCU_CONTROL);
    wire        unlocked  = mcu_control[`EIS_BIT_UNLOCK];
    wire        vsel      = mcu_control[`EIS_BIT_VSEL];
    wire [23:0] pc_mask   = {pin_change_mask_two, pin_change_mask_one, pin_change_mask_zero};
    wire        lock_kill = (vsel && !in_boot && sys_control[`EIS_BIT_APP_LOCK]) ||
                            (!vsel && in_boot && sys_control[`EIS_BIT_BOOT_LOCK]);

    // Pins are stable once stages two and three agree; stage one feeds stage two only
    // Dedicated pins idle high, so their samples reset high to avoid a false edge
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            smp_q0 <= 8'hFF;
            smp_q1 <= 8'hFF;
            smp_q2 <= 8'hFF;
            pc_q0  <= 24'h00_0000;
            pc_q1  <= 24'h00_0000;
            pc_q2  <= 24'h00_0000;
        end else begin
            smp_q0 <= dedicated_irq_pins;
            smp_q1 <= smp_q0;
            smp_q2 <= smp_q1;
            pc_q0  <= pin_change_inputs;
            pc_q1  <= pc_q0;
            pc_q2  <= pc_q1;
        end
    end

    // Core status levels come from another domain as well
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            lvl_s1 <= 3'h0;
            lvl_s2 <= 3'h0;
            lvl_s3 <= 3'h0;
        end else begin
            lvl_s1 <= {startup_done, instr_done, 1'b0};
            lvl_s2 <= lvl_s1;
            lvl_s3 <= lvl_s2;
        end
    end

    // Edge and level decode against the held previous value
    always @* begin
        sense_all = {ext_sense_control_high, ext_sense_control_low};
        for (i = 0; i < 8; i = i + 1) begin
            pin_now[i] = (smp_q1[i] == smp_q2[i]) ? smp_q2[i] : smp_prev[i];
            case (sense_all[2*i +: 2])
                `EIS_SENSE_ANY:  hit[i] = pin_now[i] ^ smp_prev[i];
                `EIS_SENSE_FALL: hit[i] = smp_prev[i] & ~pin_now[i];
                `EIS_SENSE_RISE: hit[i] = ~smp_prev[i] & pin_now[i];
                default:         hit[i] = 1'b0;
            endcase
        end
        next_flags = ext_irq_flags;
        if (reg_wr && reg_addr == `EIS_ADDR_IRQ_FLAGS)
            next_flags = next_flags & ~reg_wdata;
        // Set beats clear so an edge that lands with the acknowledge is not lost
        next_flags = (next_flags & ~handler_ack) | hit;
        for (i = 0; i < 8; i = i + 1) begin
            if (sense_all[2*i +: 2] == `EIS_SENSE_LEVEL)
                next_flags[i] = 1'b0;
        end
        // A pin-change input counts once stages two and three agree
        pc_diff = pc_q1 ^ pc_q2;
        pc_now  = (pc_q2 & ~pc_diff) | (pc_prev & pc_diff);
        grp_hit[0] = |((pc_now ^ pc_prev) & pc_mask & 24'h00_00FF);
        grp_hit[1] = |((pc_now ^ pc_prev) & pc_mask & 24'h00_FF00);
        grp_hit[2] = |((pc_now ^ pc_prev) & pc_mask & 24'hFF_0000);
        grp_hit = grp_hit & pc_enable;
        next_pc_flags = pc_flags;
        if (reg_wr && reg_addr == `EIS_ADDR_PC_FLAGS)
            next_pc_flags = next_pc_flags & ~reg_wdata[2:0];
        next_pc_flags = (next_pc_flags & ~group_ack) | grp_hit;
        case (boot_size_fuses)
            2'b00:   boot_start = 18'h3_E000;
            2'b01:   boot_start = 18'h3_F000;
            2'b10:   boot_start = 18'h3_F800;
            default: boot_start = 18'h3_FC00;
        endcase
    end

    // Level requests follow the pin itself; edge requests follow the flag
    always @* begin
        for (j = 0; j < 8; j = j + 1) begin
            if (sense_all[2*j +: 2] == `EIS_SENSE_LEVEL)
                next_req[j] = gie && ext_irq_mask[j] && !pin_now[j] &&
                              lvl_s3[2] && lvl_s2[2];
            else
                next_req[j] = gie && ext_irq_mask[j] && ext_irq_flags[j];
        end
    end

    // Unmapped addresses read as zero
    always @* begin
        next_rdata = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                `EIS_ADDR_MCU_CONTROL:  next_rdata = mcu_control;
                `EIS_ADDR_SENSE_LOW:    next_rdata = ext_sense_control_low;
                `EIS_ADDR_SENSE_HIGH:   next_rdata = ext_sense_control_high;
                `EIS_ADDR_IRQ_MASK:     next_rdata = ext_irq_mask;
                `EIS_ADDR_IRQ_FLAGS:    next_rdata = ext_irq_flags;
                `EIS_ADDR_PC_CONTROL:   next_rdata = {5'h00, pc_enable};
                `EIS_ADDR_PC_FLAGS:     next_rdata = {5'h00, pc_flags};
                `EIS_ADDR_PC_MASK_ZERO: next_rdata = pin_change_mask_zero;
                `EIS_ADDR_PC_MASK_ONE:  next_rdata = pin_change_mask_one;
                `EIS_ADDR_PC_MASK_TWO:  next_rdata = pin_change_mask_two;
                `EIS_ADDR_SYS_CONTROL:  next_rdata = sys_control;
                default:                next_rdata = 8'h00;
            endcase
        end
    end

    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            smp_prev <= 8'hFF;
            pc_prev  <= 24'h00_0000;
        end else begin
            smp_prev <= pin_now;
            pc_prev  <= pc_now;
        end
    end

    // Flags: a set in the same cycle as a clear wins
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ext_irq_flags <= `EIS_RST_BYTE;
            pc_flags      <= 3'h0;
        end else begin
            ext_irq_flags <= next_flags;
            pc_flags      <= next_pc_flags;
        end
    end

    // Plain read-write registers
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ext_sense_control_low <= `EIS_RST_BYTE;
        end else if (reg_wr && reg_addr == `EIS_ADDR_SENSE_LOW) begin
            ext_sense_control_low <= reg_wdata;
        end
    end

    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ext_sense_control_high <= `EIS_RST_BYTE;
        end else if (reg_wr && reg_addr == `EIS_ADDR_SENSE_HIGH) begin
            ext_sense_control_high <= reg_wdata;
        end
    end

    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ext_irq_mask <= `EIS_RST_BYTE;
        end else if (reg_wr && reg_addr == `EIS_ADDR_IRQ_MASK) begin
            ext_irq_mask <= reg_wdata;
        end
    end

    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pc_enable <= 3'h0;
        end else if (reg_wr && reg_addr == `EIS_ADDR_PC_CONTROL) begin
            pc_enable <= reg_wdata[2:0];
        end
    end

    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pin_change_mask_zero <= `EIS_RST_BYTE;
        end else if (reg_wr && reg_addr == `EIS_ADDR_PC_MASK_ZERO) begin
            pin_change_mask_zero <= reg_wdata;
        end
    end

    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pin_change_mask_one <= `EIS_RST_BYTE;
        end else if (reg_wr && reg_addr == `EIS_ADDR_PC_MASK_ONE) begin
            pin_change_mask_one <= reg_wdata;
        end
    end

    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pin_change_mask_two <= `EIS_RST_BYTE;
        end else if (reg_wr && reg_addr == `EIS_ADDR_PC_MASK_TWO) begin
            pin_change_mask_two <= reg_wdata;
        end
    end

    // Only the low four bits exist
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sys_control <= `EIS_RST_BYTE;
        end else if (reg_wr && reg_addr == `EIS_ADDR_SYS_CONTROL) begin
            sys_control <= reg_wdata & 8'h0F;
        end
    end

    // Relocation guard
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            mcu_control <= `EIS_RST_BYTE;
            unlock_cnt  <= 3'h0;
            block_tail  <= 1'b0;
        end else begin
            if (wr_mcu) begin
                mcu_control[`EIS_BIT_JTD] <= reg_wdata[`EIS_BIT_JTD];
                mcu_control[`EIS_BIT_PUD] <= reg_wdata[`EIS_BIT_PUD];
            end
            // Select only moves inside the open window, so stray writes cannot relocate
            if (wr_mcu && unlocked && !reg_wdata[`EIS_BIT_UNLOCK]) begin
                mcu_control[`EIS_BIT_VSEL]   <= reg_wdata[`EIS_BIT_VSEL];
                mcu_control[`EIS_BIT_UNLOCK] <= 1'b0;
                unlock_cnt <= 3'h0;
                block_tail <= 1'b1;
            end else if (wr_mcu && reg_wdata[`EIS_BIT_UNLOCK]) begin
                mcu_control[`EIS_BIT_UNLOCK] <= 1'b1;
                unlock_cnt <= `EIS_UNLOCK_WIN_CYC;
            end else if (unlock_cnt != 3'h0) begin
                unlock_cnt <= unlock_cnt - 3'h1;
                if (unlock_cnt == 3'h1)
                    mcu_control[`EIS_BIT_UNLOCK] <= 1'b0;
            end
            if (block_tail && lvl_s3[1] == lvl_s2[1] && lvl_s2[1])
                block_tail <= 1'b0;
        end
    end

    // Outputs registered; blocking is its own output and gates neither the requests nor the global enable
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ext_irq_req   <= 8'h00;
            group_irq_req <= 3'h0;
            irq_block     <= 1'b0;
            vector_base   <= 18'h0_0000;
            reg_rdata     <= 8'h00;
        end else begin
            irq_block <= unlocked || block_tail || lock_kill;
            vector_base <= vsel ? boot_start : 18'h0_0000;
            ext_irq_req   <= next_req;
            group_irq_req <= {3{gie}} & pc_enable & pc_flags;
            reg_rdata     <= next_rdata;
        end
    end

endmodule

`default_nettype wire

/* File: testbench/eis_props.sv */
// Port-level checker for the interrupt front end
`include "eis_map.vh"
`default_nettype none
module eis_props (
    // Clock and reset
    input wire logic        ref_clk,
    input wire logic        sys_rst,
    // Register port
    input wire logic [7:0]  reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic        reg_wr,
    // Pins and core
    input wire logic [7:0]  dedicated_irq_pins,
    input wire logic [23:0] pin_change_inputs,
    input wire logic [1:0]  boot_size_fuses,
    input wire logic [7:0]  handler_ack,
    input wire logic [2:0]  group_ack,
    // Outputs
    input wire logic [7:0]  ext_irq_req,
    input wire logic [2:0]  group_irq_req,
    input wire logic        irq_block,
    input wire logic [17:0] vector_base
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    logic        wr_mcu;
    logic [17:0] boot_start;
    assign wr_mcu = reg_wr && reg_addr == `EIS_ADDR_MCU_CONTROL;
    assign boot_start = boot_size_fuses == 2'h0 ? 18'h3_E000 : boot_size_fuses == 2'h1 ?
        18'h3_F000 : boot_size_fuses == 2'h2 ? 18'h3_F800 : 18'h3_FC00;
    property p_vbase; $stable(boot_size_fuses) |->
        vector_base == 18'h0_0000 || vector_base == boot_start; endproperty
    a_vbase: assert property (p_vbase) else $error("vector base off table");
    property p_blk_set; wr_mcu && reg_wdata[0] |-> ##3 irq_block; endproperty
    a_blk_set: assert property (p_blk_set) else $error("no block after unlock");
    // Without a select write the block must lapse with the unlock window
    property p_blk_end; wr_mcu && reg_wdata[0] ##1 (!wr_mcu) [*6] |-> ##[0:2] !irq_block;
    endproperty
    a_blk_end: assert property (p_blk_end) else $error("block outlived window");
    property p_vhold; (!wr_mcu && $stable(boot_size_fuses)) [*4] |=> $stable(vector_base);
    endproperty
    a_vhold: assert property (p_vhold) else $error("base moved without write");
    property p_gclr; ($stable(pin_change_inputs[7:0]) && !reg_wr) [*5] ##0 group_ack[0]
        |-> ##[1:3] !group_irq_req[0]; endproperty
    a_gclr: assert property (p_gclr) else $error("group ack ignored");
    property p_dclr; ($stable(dedicated_irq_pins[4]) && dedicated_irq_pins[4] && !reg_wr) [*5]
        ##0 handler_ack[4] |-> ##[1:3] !ext_irq_req[4]; endproperty
    a_dclr: assert property (p_dclr) else $error("handler ack ignored");
    property p_pcq; (!reg_wr && $stable(pin_change_inputs[7:0])) [*6] |=>
        !$rose(group_irq_req[0]); endproperty
    a_pcq: assert property (p_pcq) else $error("group request without change");
    property p_dq; (!reg_wr && handler_ack == 8'h00 && $stable(dedicated_irq_pins[7:4])) [*6]
        |=> $stable(ext_irq_req[7:4]); endproperty
    a_dq: assert property (p_dq) else $error("sampled pin request moved");
endmodule
`default_nettype wire

/* File: testbench/eis_pin_model.sv */
// Board-level driver of the dedicated and pin-change inputs
`default_nettype none
module eis_pin_model (
    // Clock
    input  wire logic        ref_clk,
    // Pins
    output var  logic [7:0]  dedicated_irq_pins,
    output var  logic [23:0] pin_change_inputs
);
    timeunit 1ns;
    timeprecision 1ps;
    // Levels persist until changed, so a low outlives the current instruction
    initial begin
        dedicated_irq_pins = 8'hFF;
        pin_change_inputs  = 24'h00_0000;
    end
    task automatic ded(input int i, input logic v);
        @(posedge ref_clk);
        dedicated_irq_pins[i] <= v;
    endtask
    task automatic pc(input int i, input logic v);
        @(posedge ref_clk);
        pin_change_inputs[i] <= v;
    endtask
endmodule
`default_nettype wire

/* File: testbench/tb_top.sv */
// Self-checking bench for the interrupt front end
`include "eis_map.vh"
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        ref_clk;
    logic        sys_rst;
    logic [7:0]  reg_addr;
    logic [7:0]  reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [7:0]  handler_ack;
    logic [2:0]  group_ack;
    logic [1:0]  boot_fuses;
    logic        instr_done;
    logic        startup_done;
    wire  [7:0]  reg_rdata;
    wire  [7:0]  ded_pins;
    wire  [23:0] pc_pins;
    wire  [7:0]  ext_irq_req;
    wire  [2:0]  group_irq_req;
    wire         irq_block;
    wire  [17:0] vector_base;
    int          fail_count;
    int          checks;
    eis_pin_model pm (.ref_clk(ref_clk), .dedicated_irq_pins(ded_pins), .pin_change_inputs(pc_pins));
    eis_top dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .dedicated_irq_pins(ded_pins),
        .pin_change_inputs(pc_pins), .boot_size_fuses(boot_fuses), .handler_ack(handler_ack),
        .group_ack(group_ack), .instr_done(instr_done), .startup_done(startup_done),
        .ext_irq_req(ext_irq_req), .group_irq_req(group_irq_req), .irq_block(irq_block),
        .vector_base(vector_base));
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge ref_clk);
        reg_wr    <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge ref_clk);
        reg_rd   <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic chk(input logic [17:0] got, input logic [17:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic w8;
        repeat (8) @(posedge ref_clk);
        #1;
    endtask
    task automatic end_sim;
        $display("checks=%0d fail_count=%0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    // Generous bound: the sequence needs well under a thousand cycles
    initial begin
        #100000;
        fail_count++;
        end_sim;
    end
    initial begin
        logic [7:0] d;
        logic [1:0] m;
        int         p;
        {sys_rst, reg_addr, reg_wdata, reg_wr, reg_rd} = {1'b1, 18'h0_0000};
        {handler_ack, group_ack, fail_count, checks} = '0;
        {boot_fuses, instr_done, startup_done} = {2'b01, 1'b1, 1'b1};
        repeat (5) @(posedge ref_clk);
        sys_rst <= 1'b0;
        rd(`EIS_ADDR_MCU_CONTROL, d);
        chk(18'(d), 18'h0_0000);
        rd(`EIS_ADDR_SENSE_LOW, d);
        chk(18'(d), 18'h0_0000);
        rd(8'h00, d);
        chk(18'(d), 18'h0_0000);
        wr(`EIS_ADDR_SYS_CONTROL, 8'h01);
        wr(`EIS_ADDR_MCU_CONTROL, 8'h01);
        wr(`EIS_ADDR_MCU_CONTROL, 8'h02);
        w8;
        rd(`EIS_ADDR_MCU_CONTROL, d);
        chk(18'(d), 18'h0_0002);
        chk(vector_base, 18'h3_F000);
        @(posedge ref_clk);
        boot_fuses <= 2'b11;
        w8;
        chk(vector_base, 18'h3_FC00);
        wr(`EIS_ADDR_MCU_CONTROL, 8'h01);
        rd(`EIS_ADDR_SYS_CONTROL, d);
        chk(18'(d), 18'h0_0001);
        chk(18'(irq_block), 18'h0_0001);
        w8;
        chk(18'(irq_block), 18'h0_0000);
        // Unlock has lapsed, so this clear of the select must be refused
        wr(`EIS_ADDR_MCU_CONTROL, 8'h00);
        rd(`EIS_ADDR_MCU_CONTROL, d);
        chk(18'(d), 18'h0_0002);
        @(posedge ref_clk);
        instr_done <= 1'b0;
        wr(`EIS_ADDR_MCU_CONTROL, 8'h01);
        wr(`EIS_ADDR_MCU_CONTROL, 8'h00);
        w8;
        chk(vector_base, 18'h0_0000);
        chk(18'(irq_block), 18'h0_0001);
        @(posedge ref_clk);
        instr_done <= 1'b1;
        w8;
        chk(18'(irq_block), 18'h0_0000);
        wr(`EIS_ADDR_SYS_CONTROL, 8'h0D);
        w8;
        chk(18'(irq_block), 18'h0_0001);
        wr(`EIS_ADDR_SYS_CONTROL, 8'h01);
        for (int i = 0; i < 8; i++) begin
            p = i < 4 ? 0 : 4;
            m = 2'(i);
            wr(`EIS_ADDR_IRQ_MASK, 8'h00);
            wr(p == 0 ? `EIS_ADDR_SENSE_LOW : `EIS_ADDR_SENSE_HIGH, {6'h00, m});
            w8;
            wr(`EIS_ADDR_IRQ_FLAGS, 8'hFF);
            wr(`EIS_ADDR_IRQ_MASK, 8'(1 << p));
            pm.ded(p, 1'b0);
            w8;
            chk(18'(ext_irq_req[p]), 18'(m != `EIS_SENSE_RISE));
            rd(`EIS_ADDR_IRQ_FLAGS, d);
            if (m == `EIS_SENSE_LEVEL) chk(18'(d[p]), 18'h0_0000);
            wr(`EIS_ADDR_IRQ_FLAGS, 8'hFF);
            w8;
            chk(18'(ext_irq_req[p]), 18'(m == `EIS_SENSE_LEVEL));
            pm.ded(p, 1'b1);
            w8;
            chk(18'(ext_irq_req[p]), 18'(m[0]));
            @(posedge ref_clk);
            handler_ack <= 8'(1 << p);
            @(posedge ref_clk);
            handler_ack <= 8'h00;
            w8;
            chk(18'(ext_irq_req[p]), 18'h0_0000);
        end
        wr(`EIS_ADDR_IRQ_MASK, 8'h00);
        wr(`EIS_ADDR_SENSE_LOW, 8'h00);
        pm.ded(0, 1'b0);
        w8;
        chk(18'(ext_irq_req[0]), 18'h0_0000);
        wr(`EIS_ADDR_SYS_CONTROL, 8'h00);
        wr(`EIS_ADDR_IRQ_MASK, 8'h01);
        w8;
        chk(18'(ext_irq_req[0]), 18'h0_0000);
        wr(`EIS_ADDR_SYS_CONTROL, 8'h01);
        w8;
        chk(18'(ext_irq_req[0]), 18'h0_0001);
        @(posedge ref_clk);
        startup_done <= 1'b0;
        w8;
        chk(18'(ext_irq_req[0]), 18'h0_0000);
        @(posedge ref_clk);
        startup_done <= 1'b1;
        pm.ded(0, 1'b1);
        wr(`EIS_ADDR_PC_MASK_ZERO, 8'h01);
        wr(`EIS_ADDR_PC_MASK_ONE, 8'hFF);
        wr(`EIS_ADDR_PC_MASK_TWO, 8'h80);
        wr(`EIS_ADDR_PC_CONTROL, 8'h05);
        wr(`EIS_ADDR_PC_FLAGS, 8'h07);
        pm.pc(0, 1'b1);
        w8;
        chk(18'(group_irq_req), 18'h0_0001);
        @(posedge ref_clk);
        group_ack <= 3'h1;
        @(posedge ref_clk);
        group_ack <= 3'h0;
        w8;
        chk(18'(group_irq_req), 18'h0_0000);
        pm.pc(1, 1'b1);
        pm.pc(8, 1'b1);
        w8;
        chk(18'(group_irq_req), 18'h0_0000);
        pm.pc(23, 1'b1);
        w8;
        chk(18'(group_irq_req), 18'h0_0004);
        wr(`EIS_ADDR_PC_FLAGS, 8'h04);
        w8;
        chk(18'(group_irq_req), 18'h0_0000);
        end_sim;
    end
endmodule
bind eis_top eis_props u_props (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .dedicated_irq_pins(dedicated_irq_pins),
    .pin_change_inputs(pin_change_inputs), .boot_size_fuses(boot_size_fuses),
    .handler_ack(handler_ack), .group_ack(group_ack), .ext_irq_req(ext_irq_req),
    .group_irq_req(group_irq_req), .irq_block(irq_block), .vector_base(vector_base));
`default_nettype wire
